// ===== src/ctrl_signal_reg_loopback.sv
// channel-8 control signals, registered mode and loopback with an axi4-lite register slave
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module ctrl_signal_reg_loopback (
	// clock, reset, enable
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic                              ce,
	// axi4-lite write address and data
	input  wire logic [ctrl_loop_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [ctrl_loop_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	// axi4-lite read
	input  wire logic [ctrl_loop_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [ctrl_loop_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	// mode pins; loopback command and mode select each with a pad sense that tells whether it is driven
	input  wire logic                              loop_cmd_n,
	input  wire logic                              loop_cmd_driven,
	input  wire logic                              reg_mode_sel,
	input  wire logic                              reg_mode_driven,
	input  wire logic                              reg_clk,
	input  wire logic                              out_en_n,
	// terminal side digital pins
	input  wire logic                              ch5_digital_in,
	input  wire logic                              ch8_digital_in,
	output logic                                   ch5_digital_out,
	output logic                                   ch8_digital_out,
	output logic                                   ch8_digital_oe,
	// line side logic levels
	input  wire logic                              ch5_line_in,
	input  wire logic                              ch8_line_in,
	output logic                                   ch5_line_out,
	output logic                                   ch8_line_out
);
	import ctrl_loop_pkg::*;

	typedef struct packed {
		// write channel
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] waddr;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		// read channel
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		// control register
		logic              dce_mode;
		// register clock edge detect and sampled transmit data
		logic              clk_prev;
		logic [SETTLE_W-1:0] warm;
		logic              tx5;
		logic              tx8;
		// pin outputs
		logic              rx5_out;
		logic              rx8_out;
		logic              line5_out;
		logic              line8_out;
		logic              oe8;
	} state_t;

	state_t           st;
	state_t           nxt_st;
	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] s;

	// every asynchronous pin passes two flops before use
	assign pins[PIN_LOOP_N]   = loop_cmd_n;
	assign pins[PIN_LOOP_DRV] = loop_cmd_driven;
	assign pins[PIN_REG_SEL]  = reg_mode_sel;
	assign pins[PIN_REG_DRV]  = reg_mode_driven;
	assign pins[PIN_REG_CLK]  = reg_clk;
	assign pins[PIN_CH5_DIN]  = ch5_digital_in;
	assign pins[PIN_CH8_DIN]  = ch8_digital_in;
	assign pins[PIN_CH5_LINE] = ch5_line_in;
	assign pins[PIN_CH8_LINE] = ch8_line_in;
	assign pins[PIN_OUT_EN_N] = out_en_n;

	pin_sync #(
		.W            (PIN_W)
	) u_sync (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.ce           (ce),
		.pin_in       (pins),
		.pin_sync_out (s)
	);

	// decoded pin levels; an undriven pad takes its pull level
	logic loop_n_lvl;
	logic reg_sel_lvl;
	logic loop_act;
	logic reg_mode;
	logic clk_edge;
	logic tx5_now;
	logic tx8_now;
	logic rx5_src;
	logic rx8_src;

	assign loop_n_lvl  = s[PIN_LOOP_DRV] ? s[PIN_LOOP_N] : LOOP_N_PULL;
	assign reg_sel_lvl = s[PIN_REG_DRV] ? s[PIN_REG_SEL] : REG_SEL_PULL;
	assign loop_act    = !loop_n_lvl;
	assign reg_mode    = reg_sel_lvl;
	// register clock only counts in registered mode; the synchroniser restarts at zero, so a
	// clock already high at reset would look like a rise until clk_prev has caught up
	assign clk_edge    = reg_mode && st.warm[SETTLE_W-1] && s[PIN_REG_CLK] && !st.clk_prev;

	// transmit data: latched on the clock rise or taken straight through
	assign tx5_now = reg_mode ? (clk_edge ? s[PIN_CH5_DIN] : st.tx5) : s[PIN_CH5_DIN];
	assign tx8_now = reg_mode ? (clk_edge ? s[PIN_CH8_DIN] : st.tx8) : s[PIN_CH8_DIN];

	// dte loopback turns transmit data back to the terminal; otherwise the line feeds receive
	assign rx5_src = (loop_act && !st.dce_mode) ? tx5_now : s[PIN_CH5_LINE];
	assign rx8_src = (loop_act && !st.dce_mode) ? tx8_now : s[PIN_CH8_LINE];

	// status word built from live block state
	logic [DATA_W-1:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[STAT_RING_IND_DIGITAL_BIT]    = !st.dce_mode && st.rx8_out;
		status_word[STAT_REMOTE_LOOP_DIGITAL_BIT] = st.dce_mode && st.rx8_out;
		status_word[STAT_LOOP_BIT]                = loop_act;
		status_word[STAT_REG_BIT]                 = reg_mode;
		status_word[STAT_DCE_BIT]                 = st.dce_mode;
		status_word[STAT_OE_BIT]                  = st.oe8;
	end

	// next state: bus slave, then the signal path
	always_comb begin
		nxt_st = st;
		// address and data are accepted in either order
		if (s_axi_awvalid && st.awready) begin
			nxt_st.aw_got = 1'h1;
			nxt_st.waddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			nxt_st.w_got = 1'h1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end
		if (s_axi_bready && st.bvalid) begin
			nxt_st.bvalid = 1'h0;
		end
		// commit one cycle after both halves are held
		if (st.aw_got && st.w_got && !st.bvalid) begin
			nxt_st.aw_got = 1'h0;
			nxt_st.w_got  = 1'h0;
			nxt_st.bvalid = 1'h1;
			nxt_st.bresp  = RESP_OKAY;
			case (st.waddr)
				CTRL_OFF: begin
					if (st.wstrb[0]) begin
						nxt_st.dce_mode = st.wdata[CTRL_DCE_BIT];
					end
				end
				STATUS_OFF: begin
					nxt_st.bresp = RESP_OKAY;   // read-only, write dropped
				end
				default: begin
					nxt_st.bresp = RESP_SLVERR;
				end
			endcase
		end
		// new halves are refused until the response is taken
		nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;

		// read answers on the same edge that takes the address
		if (s_axi_rready && st.rvalid) begin
			nxt_st.rvalid = 1'h0;
		end
		if (s_axi_arvalid && st.arready) begin
			nxt_st.rvalid = 1'h1;
			nxt_st.rresp  = RESP_OKAY;
			case (s_axi_araddr)
				CTRL_OFF: begin
					nxt_st.rdata = '0;
					nxt_st.rdata[CTRL_DCE_BIT] = st.dce_mode;
				end
				STATUS_OFF: begin
					nxt_st.rdata = status_word;
				end
				default: begin
					nxt_st.rdata = '0;
					nxt_st.rresp = RESP_SLVERR;
				end
			endcase
		end
		nxt_st.arready = !nxt_st.rvalid;

		// signal path
		nxt_st.clk_prev = s[PIN_REG_CLK];
		nxt_st.warm     = {st.warm[SETTLE_W-2:0], 1'h1};
		nxt_st.tx5      = tx5_now;
		nxt_st.tx8      = tx8_now;
		// receive outputs move only on the clock rise in registered mode
		if (!reg_mode || clk_edge) begin
			nxt_st.rx5_out = rx5_src;
			nxt_st.rx8_out = rx8_src;
		end
		// dce loopback echoes the line back; otherwise transmit data goes out
		nxt_st.line5_out = (loop_act && st.dce_mode) ? s[PIN_CH5_LINE] : tx5_now;
		nxt_st.line8_out = (loop_act && st.dce_mode) ? s[PIN_CH8_LINE] : tx8_now;
		nxt_st.oe8       = !s[PIN_OUT_EN_N];
	end

	// all state in one register; ce low freezes everything, bus included
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st          <= '0;
			st.dce_mode <= CTRL_RESET;
		end else if (ce) begin
			st <= nxt_st;
		end
	end

	// outputs straight from flops
	assign s_axi_awready   = st.awready;
	assign s_axi_wready    = st.wready;
	assign s_axi_bvalid    = st.bvalid;
	assign s_axi_bresp     = st.bresp;
	assign s_axi_arready   = st.arready;
	assign s_axi_rvalid    = st.rvalid;
	assign s_axi_rdata     = st.rdata;
	assign s_axi_rresp     = st.rresp;
	assign ch5_digital_out = st.rx5_out;
	assign ch8_digital_out = st.rx8_out;
	assign ch8_digital_oe  = st.oe8;
	assign ch5_line_out    = st.line5_out;
	assign ch8_line_out    = st.line8_out;

	// dte loopback returns the terminal's own channel-8 data in direct mode
	dte_loop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && loop_act && !st.dce_mode && !reg_mode |=> ch8_digital_out == $past(s[PIN_CH8_DIN]))
		else $error("dte loopback did not return channel-8 data");

	// dce loopback echoes the line input back to the line
	dce_loop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && loop_act && st.dce_mode |=> ch8_line_out == $past(s[PIN_CH8_LINE]))
		else $error("dce loopback did not echo the line");

	// an undriven loopback pad never enables loopback
	loop_pull_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!s[PIN_LOOP_DRV] |-> !loop_act)
		else $error("undriven loopback input enabled loopback");

	// channel-8 transmit reaches the line in direct mode without loopback
	line8_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !loop_act && !reg_mode |=> ch8_line_out == $past(s[PIN_CH8_DIN]))
		else $error("channel-8 line output does not follow input");

	// line state reaches the terminal and the matching status bit
	rx8_ind_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !loop_act && !reg_mode && st.dce_mode
		|=> ch8_digital_out == $past(s[PIN_CH8_LINE])
			&& (status_word[STAT_REMOTE_LOOP_DIGITAL_BIT] == ch8_digital_out || !st.dce_mode))
		else $error("remote loop indicator not passed in dce mode");

	ring_ind_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !loop_act && !reg_mode && !st.dce_mode && $stable(st.dce_mode)
		|=> ch8_digital_out == $past(s[PIN_CH8_LINE]))
		else $error("ring indicator not passed in dte mode");

	// synchronised enable pin drives the output enable one cycle later
	out_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aresetn && ce |=> ch8_digital_oe == !$past(s[PIN_OUT_EN_N]))
		else $error("output enable does not follow enable pin");

	// a driven mode pin selects the mode
	mode_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s[PIN_REG_DRV] |-> reg_mode == s[PIN_REG_SEL])
		else $error("mode select pin ignored");

	// clock rise captures both transmit inputs
	tx_sample_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && clk_edge |=> st.tx5 == $past(s[PIN_CH5_DIN]) && st.tx8 == $past(s[PIN_CH8_DIN]))
		else $error("transmit inputs not sampled on register clock");

	// receive outputs hold in registered mode without a clock rise
	rx_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && reg_mode && !clk_edge |=> $stable(ch5_digital_out) && $stable(ch8_digital_out))
		else $error("receive output moved without register clock");

	// direct mode passes channel-5 receive every cycle
	direct_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !reg_mode
		|=> ch5_digital_out == $past((loop_act && !st.dce_mode) ? s[PIN_CH5_DIN] : s[PIN_CH5_LINE]))
		else $error("direct mode did not pass channel-5 receive");

	// undriven mode pad gives direct mode
	reg_pull_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!s[PIN_REG_DRV] |-> !reg_mode)
		else $error("undriven mode input selected registered mode");

	// sampled transmit values hold between clock rises
	tx_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && reg_mode && !clk_edge |=> $stable(st.tx5) && $stable(st.tx8))
		else $error("sampled transmit value changed between clock rises");

	// a register clock rise without loopback moves both receive outputs to the line levels
	rx_update_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && clk_edge && !loop_act
		|=> ch8_digital_out == $past(s[PIN_CH8_LINE]) && ch5_digital_out == $past(s[PIN_CH5_LINE]))
		else $error("receive outputs not updated on register clock");

	// direct mode never sees a register clock edge
	clk_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!reg_mode |-> !clk_edge)
		else $error("register clock used in direct mode");

	// dce loopback still hands the line state to the terminal
	dce_rx_line_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && loop_act && st.dce_mode && !reg_mode |=> ch8_digital_out == $past(s[PIN_CH8_LINE]))
		else $error("dce loopback cut the remote loop indicator");

	// dte loopback still sends the terminal's data to the line
	dte_line_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && loop_act && !st.dce_mode && !reg_mode |=> ch8_line_out == $past(s[PIN_CH8_DIN]))
		else $error("dte loopback cut the line output");

	// a low clock enable freezes outputs, bus included; a stall is traded for quiet pins
	ce_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!ce |=> $stable(ch8_digital_out) && $stable(ch8_line_out) && $stable(s_axi_bvalid))
		else $error("state moved while clock enable was low");

endmodule : ctrl_signal_reg_loopback

// ===== shared/ctrl_loop_pkg.sv
// constants and register map for the channel-8 control, registered mode and loopback block
// Function
// - loopback active while command input low; path by mode
// - undriven loopback command input reads as high
// - channel-8 digital input goes to line output
// - dce mode: channel-8 line in is remote loop
// - dte mode: channel-8 line in is ring
// - channel-8 digital output floats while enable high
// - mode select high registered, low direct
// - registered mode samples transmit inputs on clock rise
// - registered mode updates receive outputs on clock rise
// - direct mode ignores register clock, passes signals through
// - undriven mode select input reads as low
package ctrl_loop_pkg;

	// bus geometry
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;

	// register byte offsets
	localparam logic [7:0]  CTRL_OFF     = 8'h00;
	localparam logic [7:0]  STATUS_OFF   = 8'h04;

	// control register fields
	localparam int          CTRL_DCE_BIT = 0;
	localparam logic        CTRL_RESET   = 1'h0;

	// status register fields
	localparam int          STAT_RING_IND_DIGITAL_BIT   = 0;
	localparam int          STAT_REMOTE_LOOP_DIGITAL_BIT = 1;
	localparam int          STAT_LOOP_BIT   = 2;
	localparam int          STAT_REG_BIT    = 3;
	localparam int          STAT_DCE_BIT    = 4;
	localparam int          STAT_OE_BIT     = 5;

	// bus responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// positions of pins in the synchroniser vector
	localparam int          PIN_W          = 10;
	localparam int          PIN_LOOP_N     = 0;
	localparam int          PIN_LOOP_DRV   = 1;
	localparam int          PIN_REG_SEL    = 2;
	localparam int          PIN_REG_DRV    = 3;
	localparam int          PIN_REG_CLK    = 4;
	localparam int          PIN_CH5_DIN    = 5;
	localparam int          PIN_CH8_DIN    = 6;
	localparam int          PIN_CH5_LINE   = 7;
	localparam int          PIN_CH8_LINE   = 8;
	localparam int          PIN_OUT_EN_N   = 9;

	// level assumed for a pin that nobody drives
	localparam logic        LOOP_N_PULL    = 1'h1;
	localparam logic        REG_SEL_PULL   = 1'h0;

	// cycles after reset before the register clock edge detector may fire
	localparam int          SETTLE_W       = 3;

endpackage : ctrl_loop_pkg

// ===== src/pin_sync.sv
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	// clock and control
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	// pins in and synchronised copy out
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync_out
);

	typedef struct packed {
		logic [W-1:0] stage1_ff;
		logic [W-1:0] stage2_ff;
	} sync_t;

	sync_t st;
	sync_t nxt_st;

	// first stage is read only by the second stage
	always_comb begin
		nxt_st           = st;
		nxt_st.stage1_ff = pin_in;
		nxt_st.stage2_ff = st.stage1_ff;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else if (ce) begin
			st <= nxt_st;
		end
	end

	assign pin_sync_out = st.stage2_ff;

endmodule : pin_sync

// ===== verification/terminal_model.sv
// terminal equipment model that drives the transmit pins of the block
`timescale 1ns/1ps
module terminal_model (
	// clock and mode
	input  wire logic aclk,
	input  wire logic dce_mode,
	// indicators raised by the terminal
	input  wire logic ring_ind,
	input  wire logic remote_loop,
	input  wire logic ch5_val,
	// pins towards the block
	output logic      ch8_digital_in,
	output logic      ch5_digital_in
);
	// defined levels from time zero, before the first edge
	initial begin
		ch8_digital_in = 1'h0;
		ch5_digital_in = 1'h0;
	end
	// indicator choice follows the mode; pins move just after an edge like real logic
	always @(posedge aclk) begin
		ch8_digital_in <= dce_mode ? ring_ind : remote_loop;
		ch5_digital_in <= ch5_val;
	end
endmodule : terminal_model

// ===== verification/ctrl_signal_reg_loopback_tb.sv
// self-checking bench for the channel-8 control, registered mode and loopback block
`timescale 1ns/1ps
module ctrl_signal_reg_loopback_tb;
	import ctrl_loop_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, loop_n, loop_drv, reg_sel, reg_drv;
	logic        reg_clk, out_en_n, ch5_in, ch8_in, ch5_out, ch8_out, ch8_oe;
	logic        ch5_line, ch8_line, ch5_lo, ch8_lo, dce, ring, rloop, ch5_val, ce_in;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, rs;
	int          miscompares = 0;
	int          tests_run = 0;

	ctrl_signal_reg_loopback dut (.aclk(aclk), .aresetn(aresetn), .ce(ce_in),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.loop_cmd_n(loop_n), .loop_cmd_driven(loop_drv), .reg_mode_sel(reg_sel),
		.reg_mode_driven(reg_drv), .reg_clk(reg_clk), .out_en_n(out_en_n),
		.ch5_digital_in(ch5_in), .ch8_digital_in(ch8_in), .ch5_digital_out(ch5_out),
		.ch8_digital_out(ch8_out), .ch8_digital_oe(ch8_oe), .ch5_line_in(ch5_line),
		.ch8_line_in(ch8_line), .ch5_line_out(ch5_lo), .ch8_line_out(ch8_lo));

	terminal_model partner (.aclk(aclk), .dce_mode(dce), .ring_ind(ring), .remote_loop(rloop),
		.ch5_val(ch5_val), .ch8_digital_in(ch8_in), .ch5_digital_in(ch5_in));

	// clock at 25 MHz
	initial begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	// both channels offered together, each released when its own ready is seen
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw, w;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		aw = 1;
		w = 1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && awready === 1'h1) begin
				awvalid <= 1'h0;
				aw = 0;
			end
			if (w && wready === 1'h1) begin
				wvalid <= 1'h0;
				w = 0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask : axi_rd

	task automatic set_mode(input logic m);
		axi_wr(CTRL_OFF, {31'h0, m}, rs);
		dce <= m;
		cyc(8);
	endtask : set_mode

	task automatic status_is(input logic [31:0] exp);
		axi_rd(STATUS_OFF, rd, rs);
		chk(rd, exp, "status word");
	endtask : status_is

	// reset value, read-back, read-only status and an unmapped place
	task automatic t_regs;
		axi_rd(CTRL_OFF, rd, rs);
		chk(rd, 32'h0, "ctrl after reset");
		axi_wr(CTRL_OFF, 32'h1, rs);
		chk(rs, RESP_OKAY, "ctrl write resp");
		axi_rd(CTRL_OFF, rd, rs);
		chk(rd, 32'h1, "ctrl read back");
		axi_wr(STATUS_OFF, 32'hffff_ffff, rs);
		chk(rs, RESP_OKAY, "status write resp");
		axi_rd(8'h10, rd, rs);
		chk(rd, 32'h0, "unmapped read data");
		chk(rs, RESP_SLVERR, "unmapped read resp");
		axi_wr(8'h10, 32'h1, rs);
		chk(rs, RESP_SLVERR, "unmapped write");
	endtask : t_regs

	// direct path in both modes; select line undriven and register clock toggling
	task automatic t_direct;
		reg_sel <= 1'h1;
		reg_drv <= 1'h0;
		for (int m = 0; m < 2; m++) begin
			set_mode(m[0]);
			ring <= 1'h1;
			rloop <= 1'h0;
			ch5_val <= m[0];
			ch5_line <= ~m[0];
			ch8_line <= 1'h1;
			reg_clk <= 1'h1;
			cyc(8);
			reg_clk <= 1'h0;
			chk(ch8_lo, m[0], "ch8 line out");
			chk(ch5_lo, m[0], "ch5 line out");
			chk({ch8_out, ch5_out}, {1'h1, ~m[0]}, "digital outs");
			status_is((32'h1 << (m ? STAT_REMOTE_LOOP_DIGITAL_BIT : STAT_RING_IND_DIGITAL_BIT))
				| (32'(m) << STAT_DCE_BIT) | (32'h1 << STAT_OE_BIT));
		end
	endtask : t_direct

	task automatic t_oe;
		out_en_n <= 1'h1;
		cyc(6);
		chk(ch8_oe, 1'h0, "oe while disabled");
		status_is((32'h1 << STAT_REMOTE_LOOP_DIGITAL_BIT) | (32'h1 << STAT_DCE_BIT));
		out_en_n <= 1'h0;
		cyc(6);
		chk(ch8_oe, 1'h1, "oe while enabled");
	endtask : t_oe

	// dte loop path, then an undriven command pin that must read high, then the dce loop path
	task automatic t_loop;
		set_mode(1'h0);
		loop_n <= 1'h0;
		loop_drv <= 1'h1;
		rloop <= 1'h1;
		ch8_line <= 1'h0;
		cyc(8);
		chk({ch8_out, ch8_lo}, 2'h3, "dte loop");
		status_is((32'h1 << STAT_RING_IND_DIGITAL_BIT) | (32'h1 << STAT_LOOP_BIT)
			| (32'h1 << STAT_OE_BIT));
		loop_drv <= 1'h0;
		cyc(8);
		chk({ch8_out, ch8_lo}, 2'h1, "undriven loop pin");
		loop_drv <= 1'h1;
		set_mode(1'h1);
		ring <= 1'h0;
		ch8_line <= 1'h1;
		cyc(8);
		chk({ch8_out, ch8_lo}, 2'h3, "dce loop");
		loop_n <= 1'h1;
		cyc(8);
		chk({ch8_out, ch8_lo}, 2'h2, "dce loop off");
	endtask : t_loop

	// registered mode: nothing moves between register clock rises
	task automatic t_reg;
		reg_drv <= 1'h1;
		reg_clk <= 1'h1;
		cyc(8);
		status_is((32'h1 << STAT_REMOTE_LOOP_DIGITAL_BIT) | (32'h1 << STAT_REG_BIT)
			| (32'h1 << STAT_DCE_BIT) | (32'h1 << STAT_OE_BIT));
		reg_clk <= 1'h0;
		ring <= 1'h1;
		ch5_val <= 1'h0;
		ch8_line <= 1'h0;
		ch5_line <= 1'h1;
		cyc(10);
		chk({ch8_lo, ch5_lo, ch8_out, ch5_out}, 4'h6, "held before rise");
		reg_clk <= 1'h1;
		cyc(6);
		chk({ch8_lo, ch5_lo}, 2'h2, "tx sampled on rise");
		chk({ch8_out, ch5_out}, 2'h1, "rx updated on rise");
		reg_sel <= 1'h0;
		cyc(8);
		status_is((32'h1 << STAT_DCE_BIT) | (32'h1 << STAT_OE_BIT));
	endtask : t_reg

	// clock enable low freezes the pins and their synchronisers
	task automatic t_ce;
		ce_in <= 1'h0;
		ch8_line <= 1'h1;
		cyc(8);
		chk(ch8_out, 1'h0, "frozen by ce");
		ce_in <= 1'h1;
		cyc(6);
		chk(ch8_out, 1'h1, "ce released");
	endtask : t_ce

	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop

	// watchdog well beyond the few hundred cycles the scenarios need
	initial begin
		repeat (6000) @(posedge aclk);
		miscompares++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		report_and_stop;
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, reg_sel, reg_drv, reg_clk} = '0;
		{out_en_n, ch5_line, ch8_line, dce, ring, rloop, ch5_val} = '0;
		{loop_n, loop_drv, ce_in} = 3'h7;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		cyc(6);
		aresetn <= 1'h1;
		cyc(2);
		t_regs;
		t_direct;
		t_oe;
		t_loop;
		t_reg;
		t_ce;
		report_and_stop;
	end
endmodule : ctrl_signal_reg_loopback_tb
